// >>> hdl/bidirectional_port_pins.sv
// two general-purpose bidirectional ports behind an apb register file
// assumes pins are outside the clock domain; serial and segment sources come
// from logic on i_clk_sys
//
// Notes on behaviour
// (RQ1) first port: eight pins driven from latches
// (RQ2) first port direction chosen per bit
// (RQ3) first port pull-up only when input and enabled
// (RQ4) reset makes every first port bit input
// (RQ5) first port shares serial and interrupt pins
// (RQ6) software leaves serial registers zero for gpio
// (RQ7) second port: four pins with output latches
// (RQ8) second port direction chosen per bit
// (RQ9) second port pull-up only when input and enabled
// (RQ10) reset makes every second port bit input
// (RQ11) second port may drive segment outputs
// (RQ12) every port bit has its own direction
// (RQ13) alternate input routed per input switch register
// (RQ14) data read: pin if input, latch if output
//
// Our own choices: the APB interface to the registers and the placing of the registers.
module bidirectional_port_pins #(
  parameter int P1_W = gpio_port_pkg::P1_WIDTH,
  parameter int P9_W = gpio_port_pkg::P9_WIDTH
) (
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [gpio_port_pkg::ADDR_W-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic o_pready,
  output logic [31:0] o_prdata,
  output logic o_pslverr,
  input wire logic [P1_W-1:0] i_p1_pin,
  output logic [P1_W-1:0] o_p1_pin,
  output logic [P1_W-1:0] o_p1_pin_oe,
  output logic [P1_W-1:0] o_p1_pullup,
  input wire logic [P9_W-1:0] i_p9_pin,
  output logic [P9_W-1:0] o_p9_pin,
  output logic [P9_W-1:0] o_p9_pin_oe,
  output logic [P9_W-1:0] o_p9_pullup,
  input wire logic i_ser_clk,
  input wire logic i_ser_dout,
  input wire logic [P9_W-1:0] i_seg_data,
  output logic o_ser_clk,
  output logic o_ser_din,
  output logic o_ext_irq,
  output logic o_alt_rx
);

  // ==========================================================================
  // parameter checks
  if (P1_W != 8) begin : g_bad_p1
    $error("first port must be 8 bits wide");
  end
  // the reset constants of the second port hold four bits only
  if (P9_W < 1 || P9_W > 4) begin : g_bad_p9
    $error("second port must be 1 to 4 bits wide");
  end

  // ==========================================================================
  // state
  typedef struct packed {
    logic [P1_W-1:0] p1_lat;
    logic [P1_W-1:0] p1_dir;
    logic [P1_W-1:0] p1_pu;
    logic [P1_W-1:0] p1_s1;
    logic [P1_W-1:0] p1_s2;
    logic [P9_W-1:0] p9_lat;
    logic [P9_W-1:0] p9_dir;
    logic [P9_W-1:0] p9_pu;
    logic [P9_W-1:0] p9_s1;
    logic [P9_W-1:0] p9_s2;
    logic [7:0] seg_sel;
    logic [7:0] cser_mode;
    logic [7:0] cser_clksel;
    logic [7:0] in_switch;
    logic [P1_W-1:0] p1_out;
    logic [P1_W-1:0] p1_oe;
    logic [P1_W-1:0] p1_puo;
    logic [P9_W-1:0] p9_out;
    logic [P9_W-1:0] p9_oe;
    logic [P9_W-1:0] p9_puo;
    logic ser_clk;
    logic ser_din;
    logic ext_irq;
    logic alt_rx;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } state_s;

  state_s s_q;
  state_s s_d;
  logic ser_act;
  logic seg_act;
  logic wr_en;
  logic [P1_W-1:0] p1_rd;
  logic [P9_W-1:0] p9_rd;

  // ==========================================================================
  // next state
  always_comb begin
    logic [31:0] rd;
    logic hit;
    rd = 32'h0;
    hit = 1'b1;
    s_d = s_q;

    // serial pins fall back to gpio only while both serial registers are zero
    ser_act = (s_q.cser_mode != 8'h00) || (s_q.cser_clksel != 8'h00); // RQ6
    seg_act = s_q.seg_sel[gpio_port_pkg::SEG_ENABLE_BIT];
    p1_rd = (s_q.p1_dir & s_q.p1_s2) | (~s_q.p1_dir & s_q.p1_lat); // RQ14
    p9_rd = (s_q.p9_dir & s_q.p9_s2) | (~s_q.p9_dir & s_q.p9_lat); // RQ14

    // pin synchronisers: first stage is read only by the second
    s_d.p1_s1 = i_p1_pin;
    s_d.p1_s2 = s_q.p1_s1;
    s_d.p9_s1 = i_p9_pin;
    s_d.p9_s2 = s_q.p9_s1;

    // apb: decode in setup, answer ready at the access phase, no wait states
    unique case (i_paddr)
      gpio_port_pkg::OFS_P1_DATA: rd[P1_W-1:0] = p1_rd;
      gpio_port_pkg::OFS_P1_DIR: rd[P1_W-1:0] = s_q.p1_dir;
      gpio_port_pkg::OFS_P1_PU: rd[P1_W-1:0] = s_q.p1_pu;
      gpio_port_pkg::OFS_P9_DATA: rd[P9_W-1:0] = p9_rd;
      gpio_port_pkg::OFS_P9_DIR: rd[P9_W-1:0] = s_q.p9_dir;
      gpio_port_pkg::OFS_P9_PU: rd[P9_W-1:0] = s_q.p9_pu;
      gpio_port_pkg::OFS_SEG_SEL: rd[7:0] = s_q.seg_sel;
      gpio_port_pkg::OFS_CSER_MODE: rd[7:0] = s_q.cser_mode;
      gpio_port_pkg::OFS_CSER_CLKSEL: rd[7:0] = s_q.cser_clksel;
      gpio_port_pkg::OFS_IN_SWITCH: rd[7:0] = s_q.in_switch;
      default: hit = 1'b0;
    endcase
    s_d.pready = i_psel && !i_penable;
    if (i_psel && !i_penable) begin
      s_d.pslverr = !hit;
      s_d.prdata = (hit && !i_pwrite) ? rd : 32'h0;
    end

    // a write lands only on the edge that completes the access
    wr_en = i_psel && i_penable && i_pwrite && s_q.pready && hit;
    if (wr_en) begin
      unique case (i_paddr)
        gpio_port_pkg::OFS_P1_DATA: s_d.p1_lat = i_pwdata[P1_W-1:0]; // RQ1
        gpio_port_pkg::OFS_P1_DIR: s_d.p1_dir = i_pwdata[P1_W-1:0]; // RQ2
        gpio_port_pkg::OFS_P1_PU: s_d.p1_pu = i_pwdata[P1_W-1:0];
        gpio_port_pkg::OFS_P9_DATA: s_d.p9_lat = i_pwdata[P9_W-1:0]; // RQ7
        gpio_port_pkg::OFS_P9_DIR: s_d.p9_dir = i_pwdata[P9_W-1:0]; // RQ8
        gpio_port_pkg::OFS_P9_PU: s_d.p9_pu = i_pwdata[P9_W-1:0];
        gpio_port_pkg::OFS_SEG_SEL: s_d.seg_sel = i_pwdata[7:0];
        gpio_port_pkg::OFS_CSER_MODE: s_d.cser_mode = i_pwdata[7:0];
        gpio_port_pkg::OFS_CSER_CLKSEL: s_d.cser_clksel = i_pwdata[7:0];
        gpio_port_pkg::OFS_IN_SWITCH: s_d.in_switch = i_pwdata[7:0];
        default: s_d.pslverr = s_q.pslverr;
      endcase
    end

    // per-bit gpio drive: latch onto pin while the bit is an output; segment data drives the second port while enabled
    for (int b = 0; b < P1_W; b++) begin
      s_d.p1_out[b] = s_q.p1_lat[b]; // RQ1
      s_d.p1_oe[b] = !s_q.p1_dir[b]; // RQ12
    end
    for (int b = 0; b < P9_W; b++) begin
      s_d.p9_out[b] = seg_act ? i_seg_data[b] : s_q.p9_lat[b]; // RQ7
      s_d.p9_oe[b] = seg_act || !s_q.p9_dir[b]; // RQ11
    end

    // serial function overrides the three shared pins
    if (ser_act) begin
      s_d.p1_out[gpio_port_pkg::PIN_SER_CLK] = i_ser_clk; // RQ5
      s_d.p1_oe[gpio_port_pkg::PIN_SER_CLK] = s_q.cser_clksel[gpio_port_pkg::CLKSEL_DRIVE_BIT];
      s_d.p1_oe[gpio_port_pkg::PIN_SER_DIN] = 1'b0;
      s_d.p1_out[gpio_port_pkg::PIN_SER_DOUT] = i_ser_dout; // RQ5
      s_d.p1_oe[gpio_port_pkg::PIN_SER_DOUT] = 1'b1;
    end

    // pull-ups only on bits that are inputs and not driven by a function
    s_d.p1_puo = s_q.p1_pu & s_q.p1_dir & ~s_d.p1_oe; // RQ3
    s_d.p9_puo = seg_act ? '0 : (s_q.p9_pu & s_q.p9_dir); // RQ9

    // alternate inputs
    s_d.ser_clk = s_q.p1_s2[gpio_port_pkg::PIN_SER_CLK];
    s_d.ser_din = s_q.p1_s2[gpio_port_pkg::PIN_SER_DIN];
    s_d.ext_irq = s_q.p1_s2[gpio_port_pkg::PIN_EXT_IRQ]; // RQ5
    // receive line idles high when the switch does not route the pin
    s_d.alt_rx = s_q.in_switch[gpio_port_pkg::ISC_RX_BIT] ?
                 s_q.p1_s2[gpio_port_pkg::PIN_ALT_RX] : 1'b1; // RQ13
  end

  // ==========================================================================
  // registers
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      s_q <= '0;
      s_q.p1_dir <= gpio_port_pkg::P1_DIR_RST[P1_W-1:0]; // RQ4
      s_q.p9_dir <= gpio_port_pkg::P9_DIR_RST[P9_W-1:0]; // RQ10
      s_q.p1_lat <= gpio_port_pkg::P1_LAT_RST[P1_W-1:0];
      s_q.p9_lat <= gpio_port_pkg::P9_LAT_RST[P9_W-1:0];
      s_q.p1_pu <= gpio_port_pkg::P1_PU_RST[P1_W-1:0];
      s_q.p9_pu <= gpio_port_pkg::P9_PU_RST[P9_W-1:0];
      s_q.seg_sel <= gpio_port_pkg::CTRL_RST;
      s_q.cser_mode <= gpio_port_pkg::CTRL_RST;
      s_q.cser_clksel <= gpio_port_pkg::CTRL_RST;
      s_q.in_switch <= gpio_port_pkg::CTRL_RST;
      s_q.alt_rx <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_pready = s_q.pready;
  assign o_prdata = s_q.prdata;
  assign o_pslverr = s_q.pslverr;
  assign o_p1_pin = s_q.p1_out;
  assign o_p1_pin_oe = s_q.p1_oe;
  assign o_p1_pullup = s_q.p1_puo;
  assign o_p9_pin = s_q.p9_out;
  assign o_p9_pin_oe = s_q.p9_oe;
  assign o_p9_pullup = s_q.p9_puo;
  assign o_ser_clk = s_q.ser_clk;
  assign o_ser_din = s_q.ser_din;
  assign o_ext_irq = s_q.ext_irq;
  assign o_alt_rx = s_q.alt_rx;

  // ==========================================================================
  // checks
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_nrst);

  property p_p1_drive;
    !s_q.p1_dir[0] |=> (o_p1_pin_oe[0] && o_p1_pin[0] == $past(s_q.p1_lat[0]));
  endproperty
  a_p1_drive: assert property (p_p1_drive) else $error("first port output not driven from latch"); // RQ1

  property p_p1_dir_write;
    (wr_en && i_paddr == gpio_port_pkg::OFS_P1_DIR) |=>
      s_q.p1_dir == $past(i_pwdata[P1_W-1:0]) ##1 o_p1_pin_oe[0] == !$past(i_pwdata[0], 2);
  endproperty
  a_p1_dir_write: assert property (p_p1_dir_write) else $error("first port direction write lost"); // RQ2

  property p_p1_pullup;
    o_p1_pullup[0] |-> $past(s_q.p1_pu[0] && s_q.p1_dir[0]);
  endproperty
  a_p1_pullup: assert property (p_p1_pullup) else $error("first port pull-up on a non-input bit"); // RQ3

  property p_p1_reset;
    $past(!i_nrst) |-> (s_q.p1_dir == {P1_W{1'b1}} && o_p1_pin_oe == '0);
  endproperty
  a_p1_reset: assert property (p_p1_reset) else $error("first port not input after reset"); // RQ4

  property p_ser_dout;
    ser_act |=> (o_p1_pin_oe[3] && o_p1_pin[3] == $past(i_ser_dout));
  endproperty
  a_ser_dout: assert property (p_ser_dout) else $error("serial data out not on its pin"); // RQ5

  property p_p9_drive;
    (!s_q.p9_dir[0] && !seg_act) |=> (o_p9_pin_oe[0] && o_p9_pin[0] == $past(s_q.p9_lat[0]));
  endproperty
  a_p9_drive: assert property (p_p9_drive) else $error("second port output not driven from latch"); // RQ7

  property p_p9_dir_write;
    (wr_en && i_paddr == gpio_port_pkg::OFS_P9_DIR) |=> s_q.p9_dir == $past(i_pwdata[P9_W-1:0]);
  endproperty
  a_p9_dir_write: assert property (p_p9_dir_write) else $error("second port direction write lost"); // RQ8

  property p_p9_pullup;
    o_p9_pullup[0] |-> $past(s_q.p9_pu[0] && s_q.p9_dir[0]);
  endproperty
  a_p9_pullup: assert property (p_p9_pullup) else $error("second port pull-up on a non-input bit"); // RQ9

  property p_p9_reset;
    $past(!i_nrst) |-> (s_q.p9_dir == {P9_W{1'b1}} && o_p9_pin_oe == '0);
  endproperty
  a_p9_reset: assert property (p_p9_reset) else $error("second port not input after reset"); // RQ10

  property p_seg;
    seg_act |=> (o_p9_pin_oe == {P9_W{1'b1}} && o_p9_pin == $past(i_seg_data));
  endproperty
  a_seg: assert property (p_seg) else $error("segment data not on second port"); // RQ11

  property p_alt_rx;
    !s_q.in_switch[gpio_port_pkg::ISC_RX_BIT] |=> o_alt_rx;
  endproperty
  a_alt_rx: assert property (p_alt_rx) else $error("receive input routed while switch is off"); // RQ13

  property p_read;
    (i_psel && !i_penable && !i_pwrite && i_paddr == gpio_port_pkg::OFS_P1_DATA) |=>
      (o_pready && o_prdata[P1_W-1:0] == $past(p1_rd));
  endproperty
  a_read: assert property (p_read) else $error("first port data read wrong"); // RQ14

  property p_p9_read;
    (i_psel && !i_penable && !i_pwrite && i_paddr == gpio_port_pkg::OFS_P9_DATA) |=>
      (o_pready && o_prdata[P9_W-1:0] == $past(p9_rd));
  endproperty
  a_p9_read: assert property (p_p9_read) else $error("second port data read wrong"); // RQ14

  property p_ser_din;
    ser_act |=> !o_p1_pin_oe[gpio_port_pkg::PIN_SER_DIN];
  endproperty
  a_ser_din: assert property (p_ser_din) else $error("serial data in pin still driven"); // RQ5

endmodule : bidirectional_port_pins

// >>> hdl/gpio_port_pkg.sv
// constants for the two bidirectional port blocks and their apb register map
// assumes a 32-bit apb master with word-aligned addresses
package gpio_port_pkg;

  // ==========================================================================
  // widths
  localparam int P1_WIDTH = 8;
  localparam int P9_WIDTH = 4;
  localparam int ADDR_W = 12;

  // ==========================================================================
  // register byte offsets
  localparam logic [11:0] OFS_P1_DATA = 12'h000;
  localparam logic [11:0] OFS_P1_DIR = 12'h004;
  localparam logic [11:0] OFS_P1_PU = 12'h008;
  localparam logic [11:0] OFS_P9_DATA = 12'h00c;
  localparam logic [11:0] OFS_P9_DIR = 12'h010;
  localparam logic [11:0] OFS_P9_PU = 12'h014;
  localparam logic [11:0] OFS_SEG_SEL = 12'h018;
  localparam logic [11:0] OFS_CSER_MODE = 12'h01c;
  localparam logic [11:0] OFS_CSER_CLKSEL = 12'h020;
  localparam logic [11:0] OFS_IN_SWITCH = 12'h024;

  // ==========================================================================
  // values after reset (direction bit high means input)
  localparam logic [7:0] P1_DIR_RST = 8'hff;
  localparam logic [3:0] P9_DIR_RST = 4'hf;
  localparam logic [7:0] P1_LAT_RST = 8'h00;
  localparam logic [3:0] P9_LAT_RST = 4'h0;
  localparam logic [7:0] P1_PU_RST = 8'h00;
  localparam logic [3:0] P9_PU_RST = 4'h0;
  localparam logic [7:0] CTRL_RST = 8'h00;

  // ==========================================================================
  // field positions
  localparam int SEG_ENABLE_BIT = 0;
  localparam int CLKSEL_DRIVE_BIT = 0;
  localparam int ISC_RX_BIT = 0;
  localparam int PIN_SER_CLK = 1;
  localparam int PIN_SER_DIN = 2;
  localparam int PIN_SER_DOUT = 3;
  localparam int PIN_EXT_IRQ = 4;
  localparam int PIN_ALT_RX = 5;

endpackage : gpio_port_pkg

// >>> tb/port_board_model.sv
// board side of one port: resolves each pin from device drive, pull-up and board drive
// assumes device outputs change on the rising edge of the same clock
module port_board_model #(
  parameter int W = 8
) (
  input wire logic i_clk,
  input wire logic [W-1:0] i_drv,
  input wire logic [W-1:0] i_drv_oe,
  input wire logic [W-1:0] i_pullup,
  input wire logic [W-1:0] i_ext,
  input wire logic [W-1:0] i_ext_en,
  output logic [W-1:0] o_level
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================================
  // pin resolution
  logic [W-1:0] float_q = '0;
  // a released line without pull-up must not look stable, so it flips each cycle
  always_ff @(posedge i_clk) float_q <= ~float_q;
  always_comb begin
    for (int b = 0; b < W; b++) begin
      if (i_drv_oe[b]) o_level[b] = i_drv[b];
      else if (i_ext_en[b]) o_level[b] = i_ext[b];
      else if (i_pullup[b]) o_level[b] = 1'b1;
      else o_level[b] = float_q[b];
    end
  end
endmodule : port_board_model

// >>> tb/bidirectional_port_pins_bench.sv
// self-checking bench for the two bidirectional ports behind apb
// assumes zero-wait apb answers and two-flop pin synchronisers
module bidirectional_port_pins_bench;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================================
  // signals
  logic clk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic pready, pslverr, e, ser_clk = 1'b0, ser_dout = 1'b0, ser_clk_o, ser_din, ext_irq, alt_rx;
  logic [7:0] p1_lvl, p1_pin, p1_oe, p1_pu, ext1 = 8'h00, ext1_en = 8'h00;
  logic [3:0] p9_lvl, p9_pin, p9_oe, p9_pu, ext9 = 4'h0, ext9_en = 4'h0, seg = 4'h0;
  int n_mismatch = 0, cmp_count = 0;
  bidirectional_port_pins bidirectional_port_pins_i (.i_clk_sys(clk), .i_nrst(nrst), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(pready),
    .o_prdata(prdata), .o_pslverr(pslverr), .i_p1_pin(p1_lvl), .o_p1_pin(p1_pin), .o_p1_pin_oe(p1_oe),
    .o_p1_pullup(p1_pu), .i_p9_pin(p9_lvl), .o_p9_pin(p9_pin), .o_p9_pin_oe(p9_oe), .o_p9_pullup(p9_pu),
    .i_ser_clk(ser_clk), .i_ser_dout(ser_dout), .i_seg_data(seg), .o_ser_clk(ser_clk_o),
    .o_ser_din(ser_din), .o_ext_irq(ext_irq), .o_alt_rx(alt_rx));
  port_board_model #(.W(8)) board1_i (.i_clk(clk), .i_drv(p1_pin), .i_drv_oe(p1_oe), .i_pullup(p1_pu),
    .i_ext(ext1), .i_ext_en(ext1_en), .o_level(p1_lvl));
  port_board_model #(.W(4)) board9_i (.i_clk(clk), .i_drv(p9_pin), .i_drv_oe(p9_oe), .i_pullup(p9_pu),
    .i_ext(ext9), .i_ext_en(ext9_en), .o_level(p9_lvl));
  initial begin
    forever #20 clk = ~clk;
  end
  // ==========================================================================
  // shared tasks
  task automatic test_done();
    if (n_mismatch == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : test_done
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // only the watchdog ends a wait for ready
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // output flops trail the write by one edge, pin reads by three
  task automatic settle();
    repeat (4) @(posedge clk);
    #1;
  endtask : settle
  // ==========================================================================
  // scenarios
  task automatic scen_port(input bit nine, input logic [7:0] dir, input logic [7:0] lat, input logic [7:0] ext);
    logic [11:0] b;
    logic [7:0] m;
    b = nine ? gpio_port_pkg::OFS_P9_DATA : gpio_port_pkg::OFS_P1_DATA;
    m = nine ? 8'h0f : 8'hff;
    @(posedge clk);
    ext1 <= ext;
    ext1_en <= nine ? 8'h00 : 8'hff;
    ext9 <= ext[3:0];
    ext9_en <= nine ? 4'hf : 4'h0;
    apb(b + 12'h004, 1'b1, {24'h0, dir});
    apb(b, 1'b1, {24'h0, lat});
    apb(b + 12'h008, 1'b1, 32'h0);
    settle();
    check(nine ? p9_oe : p1_oe, ~dir & m);
    check(nine ? p9_pin & p9_oe : p1_pin & p1_oe, lat & ~dir & m);
    check(nine ? p9_pu : p1_pu, 8'h00);
    apb(b, 1'b0, 32'h0);
    check(r, (lat & ~dir | ext & dir) & m);
    ext1_en <= 8'h00;
    ext9_en <= 4'h0;
    apb(b + 12'h008, 1'b1, 32'hff);
    settle();
    check(nine ? p9_pu : p1_pu, dir & m);
    apb(b, 1'b0, 32'h0);
    check(r, (lat & ~dir | dir) & m);
  endtask : scen_port
  task automatic scen_reset();
    @(posedge clk);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    check({p1_oe, p9_oe, p1_pu, p9_pu}, 24'h0);
    @(posedge clk);
    nrst <= 1'b1;
    for (int i = 1; i < 11; i++) begin
      if (i != 3) begin
        apb(12'(4 * i), 1'b0, 32'h0);
        check({31'h0, e}, {31'h0, i == 10});
        check(r, i == 1 ? 32'hff : (i == 4 ? 32'hf : 32'h0));
      end
    end
  endtask : scen_reset
  task automatic scen_alt();
    @(posedge clk);
    ext1 <= 8'h14;
    ext1_en <= 8'hff;
    ser_clk <= 1'b1;
    ser_dout <= 1'b1;
    seg <= 4'ha;
    apb(gpio_port_pkg::OFS_CSER_CLKSEL, 1'b1, 32'h1);
    apb(gpio_port_pkg::OFS_SEG_SEL, 1'b1, 32'h1);
    apb(gpio_port_pkg::OFS_IN_SWITCH, 1'b1, 32'h1);
    settle();
    check({p1_oe[3:1], p1_pin[3], p1_pin[1], ser_clk_o, ser_din, ext_irq}, 8'hbf);
    check({p9_oe, p9_pin, p9_pu, alt_rx}, 13'h1f40);
    apb(gpio_port_pkg::OFS_CSER_CLKSEL, 1'b1, 32'h0);
    apb(gpio_port_pkg::OFS_CSER_MODE, 1'b1, 32'h1);
    ext1 <= 8'h20;
    settle();
    check({p1_oe[3:1], ser_din, ext_irq, alt_rx}, 6'b100001);
    apb(gpio_port_pkg::OFS_CSER_MODE, 1'b1, 32'h0);
    apb(gpio_port_pkg::OFS_SEG_SEL, 1'b1, 32'h0);
    apb(gpio_port_pkg::OFS_IN_SWITCH, 1'b1, 32'h0);
    ext1 <= 8'h00;
    settle();
    check({p1_oe, p9_oe, alt_rx}, 13'h1);
  endtask : scen_alt
  // ==========================================================================
  // sequence and watchdog
  initial begin
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    scen_port(1'b0, 8'h5a, 8'ha5, 8'h3c);
    scen_port(1'b1, 8'h06, 8'h09, 8'h0c);
    scen_reset();
    scen_alt();
    test_done();
  end
  initial begin
    repeat (5000) @(posedge clk);
    n_mismatch++;
    test_done();
  end
endmodule : bidirectional_port_pins_bench
